// ### hw/cbsf_cfg.svh
// Constants for the branch, shift and flag execution block.
`ifndef CBSF_CFG_SVH
`define CBSF_CFG_SVH
`define CBSF_FLAG_C 3'd0
`define CBSF_FLAG_Z 3'd1
`define CBSF_FLAG_N 3'd2
`define CBSF_FLAG_V 3'd3
`define CBSF_FLAG_S 3'd4
`define CBSF_FLAG_H 3'd5
`define CBSF_FLAG_T 3'd6
`define CBSF_FLAG_I 3'd7
`define CBSF_STATUS_REGISTER_RST 8'h00
`define CBSF_PC_RST 16'h0000
`define CBSF_X_RST 16'h0000
`define CBSF_REG_X_LO 5'd26
`define CBSF_REG_X_HI 5'd27
`endif

// ### hw/cbsf_pkg.sv
// Types for the branch, shift and flag execution block.
package cbsf_pkg;
    typedef enum logic [4:0]
    {
        CBSF_OP_NONE,
        CBSF_OP_BRANCH_SIGNED_GE,
        CBSF_OP_BRANCH_SIGNED_LT,
        CBSF_OP_BRANCH_HALFCARRY_SET,
        CBSF_OP_BRANCH_HALFCARRY_CLEAR,
        CBSF_OP_BRANCH_TRANSFER_SET,
        CBSF_OP_BRANCH_TRANSFER_CLEAR,
        CBSF_OP_BRANCH_OVERFLOW_SET,
        CBSF_OP_BRANCH_OVERFLOW_CLEAR,
        CBSF_OP_BRANCH_IRQ_ENABLED,
        CBSF_OP_BRANCH_IRQ_DISABLED,
        CBSF_OP_IO_BIT_SET,
        CBSF_OP_IO_BIT_CLEAR,
        CBSF_OP_LOGICAL_LEFT_SHIFT,
        CBSF_OP_LOGICAL_RIGHT_SHIFT,
        CBSF_OP_ROTATE_LEFT_CARRY,
        CBSF_OP_ROTATE_RIGHT_CARRY,
        CBSF_OP_ARITH_RIGHT_SHIFT,
        CBSF_OP_STATUS_BIT_SET,
        CBSF_OP_STATUS_BIT_CLEAR,
        CBSF_OP_BIT_TO_TRANSFER,
        CBSF_OP_TRANSFER_TO_BIT,
        CBSF_OP_INDIRECT_LOAD_POSTINC,
        CBSF_OP_INDIRECT_LOAD_PREDEC
    } cbsf_op_t;

    typedef struct packed
    {
        cbsf_op_t    op;
        logic [4:0]  rd;
        logic [2:0]  bitsel;
        logic [4:0]  io_addr;
        logic [6:0]  offset;
    } cbsf_instr_t;

    typedef struct packed
    {
        logic        we;
        logic [4:0]  addr;
        logic [7:0]  data;
    } cbsf_rf_wr_t;
endpackage

// ### hw/cbsf_core.sv
// Execution of branch, shift, flag and indirect load instructions.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cbsf_cfg.svh"
// Summary of operation
// (RULE_01) Signed ge branch taken when N xor V zero.
// (RULE_02) Signed lt branch taken when N xor V one.
// (RULE_03) Half-carry branches test H set or clear.
// (RULE_04) Transfer branches test T set or clear.
// (RULE_05) Overflow branches test V set or clear.
// (RULE_06) Interrupt branches test I set or clear.
// (RULE_07) I/O bit set/clear, two cycles, flags kept.
// (RULE_08) Logical shifts fill zero, update Z C N V.
// (RULE_09) Rotates pass bit through carry, update flags.
// (RULE_10) Arithmetic right shift keeps sign bit.
// (RULE_11) Set or clear any single status flag.
// (RULE_12) Copy register bit to T and back.
// (RULE_13) Load at X then increment X.
// (RULE_14) Decrement X then load at new X.
// (RULE_15) Branch false one cycle, taken two; signed k.
module cbsf_core
(
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 instr_valid,
    input  wire cbsf_pkg::cbsf_instr_t instr,
    input  wire logic [7:0]           rf_rd_data,
    input  wire logic [15:0]          x_ptr,
    input  wire logic [7:0]           io_rd_data,
    input  wire logic [7:0]           dmem_rd_data,
    output logic                      busy,
    output logic                      done,
    output logic [15:0]               pc,
    output logic [7:0]                status_register,
    output cbsf_pkg::cbsf_rf_wr_t     rf_wr,
    output logic                      x_we,
    output logic [15:0]               x_wr_data,
    output logic                      io_rd,
    output logic                      io_we,
    output logic [4:0]                io_addr,
    output logic [7:0]                io_wr_data,
    output logic                      dmem_rd,
    output logic [15:0]               dmem_addr
);
    import cbsf_pkg::*;

    typedef enum logic [1:0]
    {
        CBSF_ST_IDLE,
        CBSF_ST_SECOND
    } cbsf_state_t;

    cbsf_state_t  state;
    cbsf_instr_t  held;

    // ============================================================
    // Decoding
    // ============================================================
    function automatic logic is_branch(input cbsf_op_t op);
        is_branch = (op >= CBSF_OP_BRANCH_SIGNED_GE) &&
                    (op <= CBSF_OP_BRANCH_IRQ_DISABLED);
    endfunction

    function automatic logic is_shift(input cbsf_op_t op);
        is_shift = (op >= CBSF_OP_LOGICAL_LEFT_SHIFT) &&
                   (op <= CBSF_OP_ARITH_RIGHT_SHIFT);
    endfunction

    function automatic logic is_io(input cbsf_op_t op);
        is_io = (op == CBSF_OP_IO_BIT_SET) || (op == CBSF_OP_IO_BIT_CLEAR);
    endfunction

    function automatic logic is_load(input cbsf_op_t op);
        is_load = (op == CBSF_OP_INDIRECT_LOAD_POSTINC) ||
                  (op == CBSF_OP_INDIRECT_LOAD_PREDEC);
    endfunction

    wire logic f_c = status_register[`CBSF_FLAG_C];
    wire logic f_n = status_register[`CBSF_FLAG_N];
    wire logic f_v = status_register[`CBSF_FLAG_V];
    wire logic f_h = status_register[`CBSF_FLAG_H];
    wire logic f_t = status_register[`CBSF_FLAG_T];
    wire logic f_i = status_register[`CBSF_FLAG_I];

    wire logic start = instr_valid && (state == CBSF_ST_IDLE);
    wire logic op_br = start && is_branch(instr.op);
    wire logic op_sh = start && is_shift(instr.op);

    logic cond;
    always_comb
    begin
        case (instr.op)
            CBSF_OP_BRANCH_SIGNED_GE:       cond = ~(f_n ^ f_v); // RULE_01
            CBSF_OP_BRANCH_SIGNED_LT:       cond = f_n ^ f_v; // RULE_02
            CBSF_OP_BRANCH_HALFCARRY_SET:   cond = f_h; // RULE_03
            CBSF_OP_BRANCH_HALFCARRY_CLEAR: cond = ~f_h; // RULE_03
            CBSF_OP_BRANCH_TRANSFER_SET:    cond = f_t; // RULE_04
            CBSF_OP_BRANCH_TRANSFER_CLEAR:  cond = ~f_t; // RULE_04
            CBSF_OP_BRANCH_OVERFLOW_SET:    cond = f_v; // RULE_05
            CBSF_OP_BRANCH_OVERFLOW_CLEAR:  cond = ~f_v; // RULE_05
            CBSF_OP_BRANCH_IRQ_ENABLED:     cond = f_i; // RULE_06
            CBSF_OP_BRANCH_IRQ_DISABLED:    cond = ~f_i; // RULE_06
            default:                        cond = 1'b0;
        endcase
    end

    // Offset is a signed word displacement added to PC plus one.
    wire logic [15:0] k_ext = {{9{instr.offset[6]}}, instr.offset}; // RULE_15
    wire logic [15:0] pc_taken = pc + k_ext + 16'h0001;
    wire logic [15:0] pc_next_seq = pc + 16'h0001;

    // ============================================================
    // Shift unit
    // ============================================================
    logic [7:0] sh_res;
    logic       sh_c;
    always_comb
    begin
        case (instr.op)
            CBSF_OP_LOGICAL_LEFT_SHIFT:
            begin
                sh_res = {rf_rd_data[6:0], 1'b0}; // RULE_08
                sh_c   = rf_rd_data[7];
            end
            CBSF_OP_LOGICAL_RIGHT_SHIFT:
            begin
                sh_res = {1'b0, rf_rd_data[7:1]}; // RULE_08
                sh_c   = rf_rd_data[0];
            end
            CBSF_OP_ROTATE_LEFT_CARRY:
            begin
                sh_res = {rf_rd_data[6:0], f_c}; // RULE_09
                sh_c   = rf_rd_data[7];
            end
            CBSF_OP_ROTATE_RIGHT_CARRY:
            begin
                sh_res = {f_c, rf_rd_data[7:1]}; // RULE_09
                sh_c   = rf_rd_data[0];
            end
            CBSF_OP_ARITH_RIGHT_SHIFT:
            begin
                sh_res = {rf_rd_data[7], rf_rd_data[7:1]}; // RULE_10
                sh_c   = rf_rd_data[0];
            end
            default:
            begin
                sh_res = rf_rd_data;
                sh_c   = f_c;
            end
        endcase
    end

    // Overflow is N xor C after the shift, sign is N xor V.
    wire logic sh_n = sh_res[7];
    wire logic sh_v = sh_n ^ sh_c;
    wire logic sh_z = (sh_res == 8'h00);

    // ============================================================
    // Status register next value
    // ============================================================
    logic [7:0] next_status;
    always_comb
    begin
        next_status = status_register;
        if (op_sh)
        begin
            next_status[`CBSF_FLAG_C] = sh_c; // RULE_08
            next_status[`CBSF_FLAG_Z] = sh_z;
            next_status[`CBSF_FLAG_N] = sh_n;
            next_status[`CBSF_FLAG_V] = sh_v;
            next_status[`CBSF_FLAG_S] = sh_n ^ sh_v;
        end
        else if (start && instr.op == CBSF_OP_STATUS_BIT_SET)
            next_status[instr.bitsel] = 1'b1; // RULE_11
        else if (start && instr.op == CBSF_OP_STATUS_BIT_CLEAR)
            next_status[instr.bitsel] = 1'b0; // RULE_11
        else if (start && instr.op == CBSF_OP_BIT_TO_TRANSFER)
            next_status[`CBSF_FLAG_T] = rf_rd_data[instr.bitsel]; // RULE_12
    end

    logic [7:0] bld_res;
    always_comb
    begin
        bld_res = rf_rd_data;
        bld_res[instr.bitsel] = f_t; // RULE_12
    end

    wire logic op_io  = is_io(instr.op);
    wire logic op_ldi = (instr.op == CBSF_OP_INDIRECT_LOAD_POSTINC);
    wire logic op_ldd = (instr.op == CBSF_OP_INDIRECT_LOAD_PREDEC);
    wire logic op_ld  = is_load(instr.op);
    wire logic two_cycle = (op_br && cond) ||
                           (start && (op_io || op_ld)); // RULE_07 RULE_15
    wire logic [15:0] x_dec = x_ptr - 16'h0001;
    wire logic [15:0] x_inc = x_ptr + 16'h0001;
    wire logic [15:0] ld_addr = op_ldd ? x_dec : x_ptr; // RULE_14

    // One comparator per bit position selects the I/O bit to change.
    wire logic [7:0] io_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_io_mask
            assign io_mask[gi] = (held.bitsel == 3'(gi));
        end
    endgenerate
    wire logic [7:0] io_new = (held.op == CBSF_OP_IO_BIT_SET) ?
                              (io_rd_data | io_mask) :
                              (io_rd_data & ~io_mask); // RULE_07

    // ============================================================
    // Sequencing
    // ============================================================
    cbsf_state_t  next_state;
    cbsf_instr_t  next_held;
    cbsf_rf_wr_t  next_rf_wr;
    logic         next_busy;
    logic         next_done;
    logic [15:0]  next_pc;
    logic         next_x_we;
    logic [15:0]  next_x_wr_data;
    logic         next_io_rd;
    logic         next_io_we;
    logic [4:0]   next_io_addr;
    logic [7:0]   next_io_wr_data;
    logic         next_dmem_rd;
    logic [15:0]  next_dmem_addr;

    // Strobes fall back to zero each cycle; data and addresses hold.
    always_comb
    begin
        next_state      = state;
        next_held       = held;
        next_busy       = busy;
        next_done       = 1'b0;
        next_pc         = pc;
        next_rf_wr      = rf_wr;
        next_rf_wr.we   = 1'b0;
        next_x_we       = 1'b0;
        next_x_wr_data  = x_wr_data;
        next_io_rd      = 1'b0;
        next_io_we      = 1'b0;
        next_io_addr    = io_addr;
        next_io_wr_data = io_wr_data;
        next_dmem_rd    = 1'b0;
        next_dmem_addr  = dmem_addr;
        case (state)
            CBSF_ST_IDLE:
            begin
                if (start)
                begin
                    next_held = instr;
                    if (two_cycle)
                    begin
                        next_state = CBSF_ST_SECOND;
                        next_busy  = 1'b1;
                    end
                    else
                    begin
                        next_done = 1'b1;
                        next_pc   = pc_next_seq; // RULE_15
                    end
                    if (op_br && cond)
                        next_pc = pc_taken; // RULE_01
                    if (op_sh)
                        next_rf_wr = '{1'b1, instr.rd, sh_res}; // RULE_10
                    if (instr.op == CBSF_OP_TRANSFER_TO_BIT)
                        next_rf_wr = '{1'b1, instr.rd, bld_res}; // RULE_12
                    if (op_io)
                    begin
                        next_io_rd   = 1'b1; // RULE_07
                        next_io_addr = instr.io_addr;
                    end
                    if (op_ld)
                    begin
                        next_dmem_rd   = 1'b1;
                        next_dmem_addr = ld_addr; // RULE_13
                        next_x_we      = 1'b1;
                        next_x_wr_data = op_ldi ? x_inc : x_dec; // RULE_14
                    end
                end
            end
            CBSF_ST_SECOND:
            begin
                // A taken branch has already moved the program counter.
                next_state = CBSF_ST_IDLE;
                next_busy  = 1'b0;
                next_done  = 1'b1;
                if (is_io(held.op))
                begin
                    next_io_we      = 1'b1;
                    next_io_wr_data = io_new; // RULE_07
                    next_pc         = pc_next_seq;
                end
                else if (is_load(held.op))
                begin
                    next_rf_wr = '{1'b1, held.rd, dmem_rd_data}; // RULE_13
                    next_pc    = pc_next_seq;
                end
            end
            default:
            begin
                next_state = CBSF_ST_IDLE;
                next_busy  = 1'b0;
            end
        endcase
    end

    // Register stage: every output comes straight from a flip-flop.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state           <= CBSF_ST_IDLE;
            held            <= '0;
            busy            <= 1'b0;
            done            <= 1'b0;
            pc              <= `CBSF_PC_RST;
            status_register <= `CBSF_STATUS_REGISTER_RST;
            rf_wr           <= '0;
            x_we            <= 1'b0;
            x_wr_data       <= `CBSF_X_RST;
            io_rd           <= 1'b0;
            io_we           <= 1'b0;
            io_addr         <= 5'h00;
            io_wr_data      <= 8'h00;
            dmem_rd         <= 1'b0;
            dmem_addr       <= 16'h0000;
        end
        else
        begin
            state           <= next_state;
            held            <= next_held;
            busy            <= next_busy;
            done            <= next_done;
            pc              <= next_pc;
            status_register <= next_status;
            rf_wr           <= next_rf_wr;
            x_we            <= next_x_we;
            x_wr_data       <= next_x_wr_data;
            io_rd           <= next_io_rd;
            io_we           <= next_io_we;
            io_addr         <= next_io_addr;
            io_wr_data      <= next_io_wr_data;
            dmem_rd         <= next_dmem_rd;
            dmem_addr       <= next_dmem_addr;
        end
    end
endmodule

// ### bench/cbsf_sva.sv
// Concurrent checks on the ports of the branch, shift and flag block.
`timescale 1ns/1ps
module cbsf_sva
(
    input wire logic                  ref_clk,
    input wire logic                  srst,
    input wire logic                  instr_valid,
    input wire cbsf_pkg::cbsf_instr_t instr,
    input wire logic [7:0]            rf_rd_data,
    input wire logic [15:0]           x_ptr,
    input wire logic                  busy,
    input wire logic                  done,
    input wire logic [15:0]           pc,
    input wire logic [7:0]            status_register,
    input wire cbsf_pkg::cbsf_rf_wr_t rf_wr,
    input wire logic                  x_we,
    input wire logic [15:0]           x_wr_data,
    input wire logic                  io_rd,
    input wire logic                  io_we,
    input wire logic [4:0]            io_addr,
    input wire logic                  dmem_rd,
    input wire logic [15:0]           dmem_addr
);
    import cbsf_pkg::*;
    // ======================================================
    // Decode
    cbsf_op_t    op;
    cbsf_instr_t ins_q;
    logic [7:0]  rd_q;
    wire         take = instr_valid && !busy;
    wire         is_br = op inside {[CBSF_OP_BRANCH_SIGNED_GE:
                                     CBSF_OP_BRANCH_IRQ_DISABLED]};
    wire         is_io = op inside {CBSF_OP_IO_BIT_SET, CBSF_OP_IO_BIT_CLEAR};
    wire         nv = status_register[2] ^ status_register[3];
    wire [15:0]  target = pc + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
    assign op = instr.op;
    always_ff @(posedge ref_clk)
    begin
        rd_q  <= rf_rd_data;
        ins_q <= instr;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // ======================================================
    // Properties
    a_branch_time:
    assert property (take && is_br |=> (done && !busy && pc == $past(pc)
        + 16'h0001) or (busy && !done && pc == $past(target) ##1 done))
        else $error("branch timing wrong");
    a_branch_flags:
    assert property (take && is_br |=> $stable(status_register))
        else $error("branch changed flags");
    a_signed_ge:
    assert property (take && op == CBSF_OP_BRANCH_SIGNED_GE && !nv |=>
        pc == $past(target)) else $error("ge branch not taken");
    a_signed_lt:
    assert property (take && op == CBSF_OP_BRANCH_SIGNED_LT && nv |=>
        pc == $past(target)) else $error("lt branch not taken");
    a_io_seq:
    assert property (take && is_io |=> io_rd && busy && io_addr ==
        ins_q.io_addr ##1 io_we && done) else $error("io sequence wrong");
    a_io_flags:
    assert property (take && is_io |=> ##1 status_register ==
        $past(status_register, 2)) else $error("io op changed flags");
    a_lsl_fill:
    assert property (take && op == CBSF_OP_LOGICAL_LEFT_SHIFT |=>
        rf_wr.we && rf_wr.addr == ins_q.rd &&
        rf_wr.data == {rd_q[6:0], 1'b0})
        else $error("left shift wrong");
    a_asr_sign:
    assert property (take && op == CBSF_OP_ARITH_RIGHT_SHIFT |=>
        rf_wr.data == {rd_q[7], rd_q[7:1]}) else $error("asr wrong");
    a_flag_set:
    assert property (take && op == CBSF_OP_STATUS_BIT_SET |=> status_register
        == ($past(status_register) | (8'h01 << ins_q.bitsel)))
        else $error("flag set wrong");
    a_bst_copy:
    assert property (take && op == CBSF_OP_BIT_TO_TRANSFER |=>
        status_register[6] == rd_q[ins_q.bitsel]) else $error("bst wrong");
    a_ld_inc:
    assert property (take && op == CBSF_OP_INDIRECT_LOAD_POSTINC |=> dmem_rd
        && x_we && dmem_addr == $past(x_ptr) && x_wr_data == $past(x_ptr)
        + 16'h0001 ##1 rf_wr.we && rf_wr.addr == $past(instr.rd, 2) && done)
        else $error("post-inc load wrong");
    a_ld_dec:
    assert property (take && op == CBSF_OP_INDIRECT_LOAD_PREDEC |=> dmem_rd
        && x_we && dmem_addr == $past(x_ptr) - 16'h0001 && x_wr_data ==
        dmem_addr ##1 rf_wr.we && rf_wr.addr == $past(instr.rd, 2) && done)
        else $error("pre-dec load wrong");
    c_taken: cover property (take && is_br ##1 busy);
    c_refused: cover property (instr_valid && busy);
    c_load: cover property (take && op == CBSF_OP_INDIRECT_LOAD_PREDEC);
endmodule

// ### bench/tb.sv
// Self-checking bench for the branch, shift and flag block.
`timescale 1ns/1ps
module tb;
    import cbsf_pkg::*;
    logic        ref_clk, srst, instr_valid, busy, done;
    logic        x_we, io_rd, io_we, dmem_rd;
    cbsf_instr_t instr;
    cbsf_rf_wr_t rf_wr;
    logic [7:0]  rf_rd_data, io_rd_data, dmem_rd_data;
    logic [7:0]  status_register, io_wr_data, m_sr;
    logic [15:0] x_ptr, pc, x_wr_data, dmem_addr, m_pc;
    logic [4:0]  io_addr;
    logic [31:0] notes[$];
    logic [31:0] note, seen;
    int          fails, samples_checked;
    cbsf_core u_dut (.ref_clk, .srst, .instr_valid, .instr, .rf_rd_data,
        .x_ptr, .io_rd_data, .dmem_rd_data, .busy, .done, .pc,
        .status_register, .rf_wr, .x_we, .x_wr_data, .io_rd, .io_we,
        .io_addr, .io_wr_data, .dmem_rd, .dmem_addr);
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ======================================================
    // Result watcher
    always @(negedge ref_clk)
        if (done === 1'b1)
        begin
            seen = {pc, status_register, rf_wr.we ? rf_wr.data :
                    io_we ? io_wr_data : 8'h00};
            note = notes.size() ? notes.pop_front() : 32'hX;
            samples_checked++;
            if (seen !== note)
            begin
                fails++;
                $display("BAD pc_flags_data exp %h seen %h", note, seen);
            end
        end
    // ======================================================
    // Driver with reference model
    task automatic issue(input cbsf_op_t op, input logic [2:0] b);
        logic [7:0] d, r;
        logic [6:0] k;
        logic       c, hit, two, hold;
        int         n;
        d = 8'($urandom);
        k = 7'($urandom);
        hold = 1'($urandom);
        c = m_sr[0];
        r = 8'h00;
        hit = 1'b0;
        case (op)
            CBSF_OP_BRANCH_SIGNED_GE: hit = !(m_sr[2] ^ m_sr[3]);
            CBSF_OP_BRANCH_SIGNED_LT: hit = m_sr[2] ^ m_sr[3];
            CBSF_OP_BRANCH_HALFCARRY_SET: hit = m_sr[5];
            CBSF_OP_BRANCH_HALFCARRY_CLEAR: hit = !m_sr[5];
            CBSF_OP_BRANCH_TRANSFER_SET: hit = m_sr[6];
            CBSF_OP_BRANCH_TRANSFER_CLEAR: hit = !m_sr[6];
            CBSF_OP_BRANCH_OVERFLOW_SET: hit = m_sr[3];
            CBSF_OP_BRANCH_OVERFLOW_CLEAR: hit = !m_sr[3];
            CBSF_OP_BRANCH_IRQ_ENABLED: hit = m_sr[7];
            CBSF_OP_BRANCH_IRQ_DISABLED: hit = !m_sr[7];
            CBSF_OP_IO_BIT_SET: r = (d ^ 8'h5A) | (8'h01 << b);
            CBSF_OP_IO_BIT_CLEAR: r = (d ^ 8'h5A) & ~(8'h01 << b);
            CBSF_OP_LOGICAL_LEFT_SHIFT: {c, r} = {d, 1'b0};
            CBSF_OP_LOGICAL_RIGHT_SHIFT: {r, c} = {1'b0, d};
            CBSF_OP_ROTATE_LEFT_CARRY: {c, r} = {d, m_sr[0]};
            CBSF_OP_ROTATE_RIGHT_CARRY: {r, c} = {m_sr[0], d};
            CBSF_OP_ARITH_RIGHT_SHIFT: {r, c} = {d[7], d};
            CBSF_OP_STATUS_BIT_SET: m_sr[b] = 1'b1;
            CBSF_OP_STATUS_BIT_CLEAR: m_sr[b] = 1'b0;
            CBSF_OP_BIT_TO_TRANSFER: m_sr[6] = d[b];
            CBSF_OP_TRANSFER_TO_BIT: r = (d & ~(8'h01 << b)) | (m_sr[6] << b);
            CBSF_OP_NONE: r = 8'h00;
            default: r = ~d;
        endcase
        if (op inside {[CBSF_OP_LOGICAL_LEFT_SHIFT:CBSF_OP_ARITH_RIGHT_SHIFT]})
            m_sr[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
        two = hit || op inside {CBSF_OP_IO_BIT_SET, CBSF_OP_IO_BIT_CLEAR,
            CBSF_OP_INDIRECT_LOAD_POSTINC, CBSF_OP_INDIRECT_LOAD_PREDEC};
        m_pc = m_pc + (hit ? {{9{k[6]}}, k} : 16'h0000) + 16'h0001;
        notes.push_back({m_pc, m_sr, r});
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= '{op, 5'($urandom), b, 5'($urandom), k};
        rf_rd_data <= d;
        io_rd_data <= d ^ 8'h5A;
        dmem_rd_data <= ~d;
        x_ptr <= 16'($urandom);
        @(posedge ref_clk);
        // A held request during busy must be ignored.
        if (hold && two)
            @(posedge ref_clk);
        instr_valid <= 1'b0;
        for (n = 0; n < 8 && done !== 1'b1; n++)
            @(negedge ref_clk);
        if (n == 8)
        begin
            fails++;
            report_and_stop();
        end
    endtask
    task automatic report_and_stop();
        if (notes.size() != 0)
            fails++;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ======================================================
    // Main sequence
    initial
    begin
        srst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        rf_rd_data = 8'h00;
        io_rd_data = 8'h00;
        dmem_rd_data = 8'h00;
        x_ptr = 16'h0000;
        m_pc = 16'h0000;
        m_sr = 8'h00;
        fails = 0;
        samples_checked = 0;
        void'($urandom(32'hDE843A37));
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 16; i++)
            issue(cbsf_op_t'(18 + i % 2), 3'(i / 2));
        $display("test flag_set_clear done");
        for (int i = 0; i < 24; i++)
            issue(cbsf_op_t'(i), 3'($urandom));
        $display("test each_op done");
        for (int i = 0; i < 800; i++)
            issue(cbsf_op_t'(1 + $urandom % 23), 3'($urandom));
        $display("test random_mix done");
        // Let the watcher take the last result before the verdict.
        repeat (2) @(posedge ref_clk);
        report_and_stop();
    end
endmodule
bind cbsf_core cbsf_sva u_sva (.ref_clk, .srst, .instr_valid, .instr,
    .rf_rd_data, .x_ptr, .busy, .done, .pc, .status_register, .rf_wr,
    .x_we, .x_wr_data, .io_rd, .io_we, .io_addr, .dmem_rd, .dmem_addr);
